// ---- rtl/cache_line_consts.vh ----
// Address fields, snoop codes and seeds for the cache line state control
`ifndef CACHE_LINE_CONSTS_VH
`define CACHE_LINE_CONSTS_VH

// ----------------------------------------
// Physical address fields
// ----------------------------------------
`define TAG_MSB 31
`define TAG_LSB 8
`define SET_MSB 7
`define SET_LSB 4
`define HALF_BIT 3
`define LW_MSB 3
`define LW_LSB 2
`define LINE_LOW 4'h0

// ----------------------------------------
// Snoop control codes
// ----------------------------------------
`define SNP_LEAVE 2'h1
`define SNP_INVAL 2'h2

// ----------------------------------------
// Misc constants
// ----------------------------------------
`define LW_ONE 4'h1
`define LFSR_SEED 8'h5a
`define LFSR_TAPS 8'hb8

`endif

// ---- rtl/cache_line_ctrl.v ----
// Line state control for the instruction and data caches
//
`timescale 1ns/1ps
`include "cache_line_consts.vh"

// Operation
// - Instruction and data caches keep separate state and serve requests apart.
// - Flow change or status word write flushes the pending prefetch delivery.
// - Instruction lines are only invalid or valid.
// - Instruction hit returns the half-line picked by address bit 3.
// - Instruction miss fills an invalid way, writing tag, data, valid.
// - With a full instruction set, a pseudo-random way is overwritten.
// - Replacing a valid instruction line delivers data and leaves it valid.
// - Read hits return cached data with no state change.
// - Invalidate or push makes a valid instruction line invalid.
// - Leave-dirty snoop reads ignore the instruction cache.
// - Invalidate snoop read hit makes an instruction line invalid.
// - Any snooped write hit invalidates an instruction line.
// - Data lines are invalid, valid or dirty.
// - Page caching policy picks write-through or copyback per access.
// - Read misses and copyback write misses allocate a full line.
// - Data fill prefers an invalid way, then sets it valid.
// - With no invalid way, a pseudo-random data way is replaced.
// - Dirty victim waits in a buffer, written after the new line.
// - Snoops also check the waiting dirty victim buffer.
// - Copyback write stores data, sets longword dirty flags, line dirty.
// - Leave-dirty snoop read on dirty line inhibits memory, sources data.
// - Invalidate on a dirty data line drops its contents.
module cache_line_ctrl
(
  input wire core_clk,
  input wire nrst,
  input wire flow_change,
  input wire processor_status_word_wr,
  input wire i_req,
  input wire [31:0] i_addr,
  output wire i_busy,
  output reg i_ack,
  output reg [63:0] i_data,
  input wire d_req,
  input wire d_wr,
  input wire [31:0] d_addr,
  input wire [31:0] d_wdata,
  input wire page_caching_policy,
  output wire d_busy,
  output reg d_ack,
  output reg [31:0] d_rdata,
  input wire op_req,
  input wire op_push,
  input wire op_dcache,
  input wire [31:0] op_addr,
  output wire op_busy,
  output reg op_ack,
  output reg line_rd_req,
  output reg [31:0] line_rd_addr,
  input wire line_rd_done,
  input wire [127:0] line_rd_data,
  output reg wt_req,
  output reg [31:0] wt_addr,
  output reg [31:0] wt_data,
  input wire wt_done,
  output wire push_req,
  output reg [31:0] push_addr,
  output reg [127:0] push_data,
  output reg [3:0] longword_dirty_flags,
  input wire push_done,
  input wire snp_valid,
  input wire snp_wr,
  input wire [1:0] snp_ctl,
  input wire [31:0] snp_addr,
  output reg snp_inhibit,
  output reg [127:0] snp_data
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_IFILL = 3'h1;
  localparam [2:0] ST_DFILL = 3'h2;
  localparam [2:0] ST_WT = 3'h3;
  localparam [2:0] ST_PUSH = 3'h4;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function [2:0] match4;
    input [95:0] tags;
    input [3:0] vld;
    input [23:0] tag;
    integer k;
    begin
      match4 = 3'h0;
      for (k = 3; k >= 0; k = k - 1)
        if (vld[k] && tags[k*24 +: 24] == tag)
          match4 = {1'b1, k[1:0]};
    end
  endfunction

  // First invalid way, else the random way
  function [1:0] pick;
    input [3:0] vld;
    input [1:0] rnd;
    integer k;
    begin
      pick = rnd;
      for (k = 3; k >= 0; k = k - 1)
        if (!vld[k])
          pick = k[1:0];
    end
  endfunction

  function [127:0] merge;
    input [127:0] line;
    input [31:0] word;
    input [1:0] lw;
    begin
      merge = line;
      merge[{lw, 5'h00} +: 32] = word;
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [2:0] st;
  reg [63:0] i_vld;
  reg [63:0] d_vld;
  reg [63:0] d_drt;
  reg [23:0] i_tag [0:63];
  reg [127:0] i_line [0:63];
  reg [23:0] d_tag [0:63];
  reg [127:0] d_line [0:63];
  reg [3:0] d_lwd [0:63];
  reg [5:0] f_idx;
  reg [23:0] f_tag;
  reg f_wr;
  reg [1:0] f_lw;
  reg f_half;
  reg [31:0] f_wdata;
  reg f_kill;
  reg pb_vld;

  wire [1:0] rand_way;
  wire flush = flow_change | processor_status_word_wr;

  way_picker u_way_picker
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .rand_way(rand_way)
  );

  // ----------------------------------------
  // Tag lookups
  // ----------------------------------------
  wire [31:0] ia = i_req ? i_addr : op_addr;
  wire [31:0] da = d_req ? d_addr : op_addr;
  wire [3:0] ia_set = ia[`SET_MSB:`SET_LSB];
  wire [3:0] da_set = da[`SET_MSB:`SET_LSB];
  wire [3:0] s_set = snp_addr[`SET_MSB:`SET_LSB];
  wire [23:0] ia_tag = ia[`TAG_MSB:`TAG_LSB];
  wire [23:0] da_tag = da[`TAG_MSB:`TAG_LSB];
  wire [23:0] s_tag = snp_addr[`TAG_MSB:`TAG_LSB];
  wire [1:0] d_lw = d_addr[`LW_MSB:`LW_LSB];
  wire [95:0] ih_tags;
  wire [95:0] is_tags;
  wire [95:0] dh_tags;
  wire [95:0] ds_tags;
  wire [3:0] ih_v;
  wire [3:0] is_v;
  wire [3:0] dh_v;
  wire [3:0] ds_v;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : way_rd
      localparam [1:0] w = g;
      assign ih_tags[g*24 +: 24] = i_tag[{ia_set, w}];
      assign is_tags[g*24 +: 24] = i_tag[{s_set, w}];
      assign dh_tags[g*24 +: 24] = d_tag[{da_set, w}];
      assign ds_tags[g*24 +: 24] = d_tag[{s_set, w}];
      assign ih_v[g] = i_vld[{ia_set, w}];
      assign is_v[g] = i_vld[{s_set, w}];
      assign dh_v[g] = d_vld[{da_set, w}];
      assign ds_v[g] = d_vld[{s_set, w}];
    end
  endgenerate

  wire [2:0] ih_hit = match4(ih_tags, ih_v, ia_tag);
  wire [2:0] is_hit = match4(is_tags, is_v, s_tag);
  wire [2:0] dh_hit = match4(dh_tags, dh_v, da_tag);
  wire [2:0] ds_hit = match4(ds_tags, ds_v, s_tag);
  wire [5:0] ih_idx = {ia_set, ih_hit[1:0]};
  wire [5:0] is_idx = {s_set, is_hit[1:0]};
  wire [5:0] dh_idx = {da_set, dh_hit[1:0]};
  wire [5:0] ds_idx = {s_set, ds_hit[1:0]};
  wire [5:0] iv_idx = {ia_set, pick(ih_v, rand_way)};
  wire [5:0] dv_idx = {da_set, pick(dh_v, rand_way)};
  wire [127:0] fill_line = f_wr ?
    merge(line_rd_data, f_wdata, f_lw) : line_rd_data;
  wire snp_on = snp_valid &&
    (snp_ctl == `SNP_LEAVE || snp_ctl == `SNP_INVAL);
  wire snp_kill = snp_wr || snp_ctl == `SNP_INVAL;
  wire pb_hit = pb_vld && snp_addr[`TAG_MSB:`SET_LSB] ==
    push_addr[`TAG_MSB:`SET_LSB];

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  assign d_busy = st != ST_IDLE;
  assign i_busy = st != ST_IDLE || d_req;
  assign op_busy = st != ST_IDLE || d_req || i_req;
  assign push_req = st == ST_PUSH;

  // ----------------------------------------
  // Line state machine
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      st <= ST_IDLE;
      i_vld <= 64'h0;
      d_vld <= 64'h0;
      d_drt <= 64'h0;
      i_ack <= 1'b0;
      i_data <= 64'h0;
      d_ack <= 1'b0;
      d_rdata <= 32'h0;
      op_ack <= 1'b0;
      line_rd_req <= 1'b0;
      line_rd_addr <= 32'h0;
      wt_req <= 1'b0;
      wt_addr <= 32'h0;
      wt_data <= 32'h0;
      push_addr <= 32'h0;
      push_data <= 128'h0;
      longword_dirty_flags <= 4'h0;
      snp_inhibit <= 1'b0;
      snp_data <= 128'h0;
      f_idx <= 6'h0;
      f_tag <= 24'h0;
      f_wr <= 1'b0;
      f_lw <= 2'h0;
      f_half <= 1'b0;
      f_wdata <= 32'h0;
      f_kill <= 1'b0;
      pb_vld <= 1'b0;
    end
    else
    begin
      i_ack <= 1'b0;
      d_ack <= 1'b0;
      op_ack <= 1'b0;
      snp_inhibit <= 1'b0;
      // Snoops are served in every state; they never stall the bus
      if (snp_on)
      begin
        if (is_hit[2] && snp_kill)
          i_vld[is_idx] <= 1'b0;
        if (ds_hit[2] && !snp_wr && d_drt[ds_idx])
        begin
          snp_inhibit <= 1'b1;
          snp_data <= d_line[ds_idx];
        end
        if (ds_hit[2] && snp_kill)
        begin
          d_vld[ds_idx] <= 1'b0;
          d_drt[ds_idx] <= 1'b0;
        end
        if (pb_hit && !snp_wr)
        begin
          snp_inhibit <= 1'b1;
          snp_data <= push_data;
        end
      end
      case (st)
        ST_IDLE:
        begin
          if (d_req)
          begin
            if (dh_hit[2] && !d_wr)
            begin
              d_rdata <= d_line[dh_idx][{d_lw, 5'h00} +: 32];
              d_ack <= 1'b1;
            end
            else if (dh_hit[2])
            begin
              d_line[dh_idx] <= merge(d_line[dh_idx], d_wdata, d_lw);
              if (page_caching_policy)
              begin
                d_drt[dh_idx] <= 1'b1;
                d_lwd[dh_idx] <= d_lwd[dh_idx] | (`LW_ONE << d_lw);
                d_ack <= 1'b1;
              end
              else
              begin
                wt_req <= 1'b1;
                wt_addr <= d_addr;
                wt_data <= d_wdata;
                st <= ST_WT;
              end
            end
            else if (d_wr && !page_caching_policy)
            begin
              wt_req <= 1'b1;
              wt_addr <= d_addr;
              wt_data <= d_wdata;
              st <= ST_WT;
            end
            else
            begin
              // Victim leaves the array now; a dirty one waits in the buffer
              if (d_vld[dv_idx] && d_drt[dv_idx])
              begin
                pb_vld <= 1'b1;
                push_data <= d_line[dv_idx];
                push_addr <= {d_tag[dv_idx], dv_idx[5:2], `LINE_LOW};
                longword_dirty_flags <= d_lwd[dv_idx];
              end
              d_vld[dv_idx] <= 1'b0;
              d_drt[dv_idx] <= 1'b0;
              f_idx <= dv_idx;
              f_tag <= da_tag;
              f_wr <= d_wr;
              f_lw <= d_lw;
              f_wdata <= d_wdata;
              line_rd_req <= 1'b1;
              line_rd_addr <= {da_tag, da_set, `LINE_LOW};
              st <= ST_DFILL;
            end
          end
          else if (i_req)
          begin
            if (ih_hit[2])
            begin
              i_data <= i_addr[`HALF_BIT] ? i_line[ih_idx][127:64] :
                i_line[ih_idx][63:0];
              i_ack <= !flush;
            end
            else
            begin
              i_vld[iv_idx] <= 1'b0;
              f_idx <= iv_idx;
              f_tag <= ia_tag;
              f_half <= i_addr[`HALF_BIT];
              f_kill <= flush;
              line_rd_req <= 1'b1;
              line_rd_addr <= {ia_tag, ia_set, `LINE_LOW};
              st <= ST_IFILL;
            end
          end
          else if (op_req)
          begin
            op_ack <= 1'b1;
            if (op_dcache && dh_hit[2])
            begin
              // Invalidate drops dirty data; push writes it out first
              if (op_push && d_drt[dh_idx])
              begin
                pb_vld <= 1'b1;
                push_data <= d_line[dh_idx];
                push_addr <= {da_tag, da_set, `LINE_LOW};
                longword_dirty_flags <= d_lwd[dh_idx];
                st <= ST_PUSH;
              end
              d_vld[dh_idx] <= 1'b0;
              d_drt[dh_idx] <= 1'b0;
            end
            else if (!op_dcache && ih_hit[2])
              i_vld[ih_idx] <= 1'b0;
          end
        end
        ST_IFILL:
        begin
          if (flush)
            f_kill <= 1'b1;
          if (line_rd_done)
          begin
            line_rd_req <= 1'b0;
            i_tag[f_idx] <= f_tag;
            i_line[f_idx] <= line_rd_data;
            i_vld[f_idx] <= 1'b1;
            i_data <= f_half ? line_rd_data[127:64] : line_rd_data[63:0];
            i_ack <= !(f_kill || flush);
            st <= ST_IDLE;
          end
        end
        ST_DFILL:
        begin
          if (line_rd_done)
          begin
            line_rd_req <= 1'b0;
            d_tag[f_idx] <= f_tag;
            d_line[f_idx] <= fill_line;
            d_vld[f_idx] <= 1'b1;
            d_drt[f_idx] <= f_wr;
            d_lwd[f_idx] <= f_wr ? (`LW_ONE << f_lw) : 4'h0;
            d_rdata <= line_rd_data[{f_lw, 5'h00} +: 32];
            d_ack <= 1'b1;
            st <= pb_vld ? ST_PUSH : ST_IDLE;
          end
        end
        ST_WT:
        begin
          if (wt_done)
          begin
            wt_req <= 1'b0;
            d_ack <= 1'b1;
            st <= ST_IDLE;
          end
        end
        ST_PUSH:
        begin
          if (push_done)
          begin
            pb_vld <= 1'b0;
            st <= ST_IDLE;
          end
        end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

endmodule

// ---- rtl/way_picker.v ----
// Pseudo-random way selector for line replacement
`timescale 1ns/1ps
`include "cache_line_consts.vh"

module way_picker
(
  input wire core_clk,
  input wire nrst,
  output wire [1:0] rand_way
);

  reg [7:0] lfsr;

  // Advances every cycle, so the pick depends on request timing
  always @(posedge core_clk)
  begin
    if (!nrst)
      lfsr <= `LFSR_SEED;
    else
      lfsr <= {lfsr[6:0], ^(lfsr & `LFSR_TAPS)};
  end

  assign rand_way = lfsr[1:0];

endmodule

// ---- testbench/bus_partner.sv ----
// Bus controller model answering line reads, write-through and pushes
`timescale 1ns/1ps
module bus_partner
(
  input wire core_clk,
  input wire nrst,
  input wire [4:0] delay,
  input wire line_rd_req,
  input wire [31:0] line_rd_addr,
  output reg line_rd_done,
  output reg [127:0] line_rd_data,
  input wire wt_req,
  output reg wt_done,
  input wire push_req,
  output reg push_done
);
  reg [4:0] cnt;
  wire pending = line_rd_req | wt_req | push_req;
  wire answered = line_rd_done | wt_done | push_done;
  function [127:0] line_of(input [31:0] a);
    line_of = {a ^ 32'h0000000c, a ^ 32'h00000008, a ^ 32'h00000004, a};
  endfunction
  always @(posedge core_clk)
  begin
    line_rd_done <= 1'b0;
    wt_done <= 1'b0;
    push_done <= 1'b0;
    // Only good with the done pulse, so stale data cannot pass
    line_rd_data <= ~line_rd_data;
    if (!nrst)
    begin
      cnt <= 5'h00;
      line_rd_data <= 128'h0;
    end
    else if (pending && !answered)
    begin
      cnt <= cnt + 5'h01;
      if (cnt >= delay)
      begin
        cnt <= 5'h00;
        line_rd_done <= line_rd_req;
        wt_done <= wt_req;
        push_done <= push_req;
        if (line_rd_req)
          line_rd_data <= line_of(line_rd_addr);
      end
    end
  end
endmodule

// ---- testbench/cache_line_ctrl_chk.sv ----
// Port assertions for the cache line state control
`timescale 1ns/1ps
module cache_line_ctrl_chk
(
  input wire core_clk,
  input wire nrst,
  input wire flow_change,
  input wire processor_status_word_wr,
  input wire i_req,
  input wire i_busy,
  input wire i_ack,
  input wire d_req,
  input wire d_busy,
  input wire d_ack,
  input wire op_req,
  input wire op_busy,
  input wire op_ack,
  input wire line_rd_req,
  input wire [31:0] line_rd_addr,
  input wire line_rd_done,
  input wire wt_req,
  input wire [31:0] wt_addr,
  input wire [31:0] wt_data,
  input wire wt_done,
  input wire push_req,
  input wire snp_valid,
  input wire snp_wr,
  input wire snp_inhibit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_d_take; d_req && !d_busy; endsequence
  sequence s_i_take;
    i_req && !i_busy && !flow_change && !processor_status_word_wr;
  endsequence
  sequence s_fill; line_rd_req && line_rd_done; endsequence
  property p_d_answer; s_d_take |=> d_ack || line_rd_req || wt_req;
  endproperty
  a_d_answer: assert property (p_d_answer)
    else $error("data request not answered");
  property p_i_answer; s_i_take |=> i_ack || line_rd_req; endproperty
  a_i_answer: assert property (p_i_answer)
    else $error("fetch request not answered");
  property p_flush; flow_change || processor_status_word_wr |=> !i_ack;
  endproperty
  a_flush: assert property (p_flush)
    else $error("fetch delivered across a flush");
  property p_op; op_req && !op_busy |=> op_ack; endproperty
  a_op: assert property (p_op)
    else $error("line operation not acknowledged");
  property p_rd_hold;
    line_rd_req && !line_rd_done |=> line_rd_req && $stable(line_rd_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("line read dropped early");
  property p_rd_drop; s_fill |=> !line_rd_req; endproperty
  a_rd_drop: assert property (p_rd_drop)
    else $error("line read held after done");
  property p_wt_hold;
    wt_req && !wt_done |=> wt_req && $stable(wt_addr) && $stable(wt_data);
  endproperty
  a_wt_hold: assert property (p_wt_hold)
    else $error("write-through changed before done");
  property p_push_alone; push_req |-> !line_rd_req && !wt_req && op_busy;
  endproperty
  a_push_alone: assert property (p_push_alone)
    else $error("push overlaps another bus request");
  property p_inhibit; snp_inhibit |-> $past(snp_valid) && !$past(snp_wr);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit without a snooped read");
endmodule

// ---- testbench/cache_line_ctrl_tb.sv ----
// Self-checking bench for the cache line state control
`timescale 1ns/1ps
module cache_line_ctrl_tb;
  reg core_clk, nrst, flow_change, processor_status_word_wr, i_req, d_req;
  reg d_wr, page_caching_policy, op_req, op_push, op_dcache, snp_valid;
  reg snp_wr;
  reg [1:0] snp_ctl;
  reg [4:0] delay;
  reg [31:0] i_addr, d_addr, d_wdata, op_addr, snp_addr, wt_a, wt_d;
  reg [127:0] ln, push_d;
  reg [3:0] flags;
  wire i_busy, i_ack, d_busy, d_ack, op_busy, op_ack, line_rd_req;
  wire line_rd_done, wt_req, wt_done, push_req, push_done, snp_inhibit;
  wire [63:0] i_data;
  wire [31:0] d_rdata, line_rd_addr, wt_addr, wt_data, push_addr;
  wire [127:0] line_rd_data, push_data, snp_data;
  wire [3:0] longword_dirty_flags;
  wire [2:0] acks = {op_ack, i_ack, d_ack};
  wire [2:0] busys = {op_busy, i_busy, d_busy};
  integer n_mismatch, n_compared, n_fill, n_push, cycles, f, p, k, w;
  cache_line_ctrl dut (.core_clk, .nrst, .flow_change,
    .processor_status_word_wr, .i_req, .i_addr, .i_busy, .i_ack, .i_data,
    .d_req, .d_wr, .d_addr, .d_wdata, .page_caching_policy, .d_busy,
    .d_ack, .d_rdata, .op_req, .op_push, .op_dcache, .op_addr, .op_busy,
    .op_ack, .line_rd_req, .line_rd_addr, .line_rd_done, .line_rd_data,
    .wt_req, .wt_addr, .wt_data, .wt_done, .push_req, .push_addr,
    .push_data, .longword_dirty_flags, .push_done, .snp_valid, .snp_wr,
    .snp_ctl, .snp_addr, .snp_inhibit, .snp_data);
  bus_partner bus (.core_clk, .nrst, .delay, .line_rd_req, .line_rd_addr,
    .line_rd_done, .line_rd_data, .wt_req, .wt_done, .push_req, .push_done);
  always #12.5 core_clk = ~core_clk;
  // ----------------------------------------
  // Bus monitor and hang guard
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (line_rd_req && line_rd_done)
      n_fill = n_fill + 1;
    if (wt_req && wt_done)
      {wt_a, wt_d} = {wt_addr, wt_data};
    if (push_req && push_done)
    begin
      n_push = n_push + 1;
      {push_d, flags} = {push_data, longword_dirty_flags};
    end
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  task chk(input [127:0] got, input [127:0] exp, input [8*16:1] what);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: %0s %h", $time, what, got);
    end
  end
  endtask
  // Kind 0 data, 1 fetch, 2 line op (wr = push, cb = data cache)
  task cpu(input [1:0] kind, input wr, input cb, input [31:0] a,
    input [31:0] w);
  begin
    {d_wr, op_push, page_caching_policy, op_dcache} <= {wr, wr, cb, cb};
    {d_addr, i_addr, op_addr, d_wdata} <= {a, a, a, w};
    {op_req, i_req, d_req} <= 3'h1 << kind;
    @(negedge core_clk);
    while (busys[kind])
      @(negedge core_clk);
    @(posedge core_clk);
    {op_req, i_req, d_req} <= 3'h0;
    w = 0;
    @(negedge core_clk);
    while (acks[kind] !== 1'b1 && w < 60)
    begin
      w = w + 1;
      @(negedge core_clk);
    end
    chk(acks[kind], 1'b1, "request ack");
    @(posedge core_clk);
  end
  endtask
  task snoop(input wr, input [1:0] ctl, input [31:0] a, input inh);
  begin
    {snp_valid, snp_wr, snp_ctl, snp_addr} <= {1'b1, wr, ctl, a};
    @(posedge core_clk);
    snp_valid <= 1'b0;
    @(negedge core_clk);
    chk(snp_inhibit, inh, "snoop inhibit");
    @(posedge core_clk);
  end
  endtask
  task t_icache;
  begin
    ln = bus.line_of(32'h00001230);
    f = n_fill;
    cpu(2'h1, 1'b0, 1'b0, 32'h00001238, 32'h0);
    chk(i_data, ln[127:64], "upper half");
    cpu(2'h1, 1'b0, 1'b0, 32'h00001230, 32'h0);
    chk(i_data, ln[63:0], "lower half");
    for (k = 1; k < 5; k = k + 1)
      cpu(2'h1, 1'b0, 1'b0, 32'h00001230 + k * 32'h100, 32'h0);
    cpu(2'h1, 1'b0, 1'b0, 32'h00001630, 32'h0);
    chk(n_fill - f, 5, "fill count");
    for (p = 0; p < 6; p = p + 1)
    begin
      f = n_fill;
      if (p < 4)
        snoop(p > 1, p % 2 ? 2'h2 : 2'h1, 32'h00001630, 1'b0);
      else
        cpu(2'h2, p == 5, 1'b0, 32'h00001630, 32'h0);
      cpu(2'h1, 1'b0, 1'b0, 32'h00001630, 32'h0);
      chk(n_fill - f, p != 0, "refetch");
    end
    // Fetch taken beside a flow change: line fills, no delivery
    f = n_fill;
    {flow_change, i_req, i_addr} <= {2'h3, 32'h00001830};
    @(posedge core_clk);
    {flow_change, i_req} <= 2'h0;
    w = 0;
    repeat (6)
    begin
      @(negedge core_clk);
      w = w | i_ack;
    end
    @(posedge core_clk);
    cpu(2'h1, 1'b0, 1'b0, 32'h00001830, 32'h0);
    chk({w, n_fill - f}, {32'h0, 32'h1}, "flushed fetch");
    $display("t_icache done");
  end
  endtask
  task t_dcache;
  begin
    ln = bus.line_of(32'h00002240);
    {f, p} = {n_fill, n_push};
    cpu(2'h0, 1'b1, 1'b1, 32'h00002248, 32'h0badcafe);
    cpu(2'h0, 1'b0, 1'b1, 32'h00002248, 32'h0);
    chk(d_rdata, 32'h0badcafe, "copyback word");
    cpu(2'h0, 1'b0, 1'b1, 32'h00002244, 32'h0);
    chk(d_rdata, ln[63:32], "filled word");
    snoop(1'b0, 2'h1, 32'h00002240, 1'b1);
    chk(snp_data, {ln[127:96], 32'h0badcafe, ln[63:0]}, "snoop");
    cpu(2'h2, 1'b1, 1'b1, 32'h00002240, 32'h0);
    cpu(2'h0, 1'b0, 1'b1, 32'h00002248, 32'h0);
    chk({flags, push_d[95:64]}, {4'h4, 32'h0badcafe}, "push");
    chk(n_fill - f, 2, "refill");
    cpu(2'h0, 1'b1, 1'b1, 32'h00002248, 32'h0badcafe);
    cpu(2'h2, 1'b0, 1'b1, 32'h00002240, 32'h0);
    cpu(2'h0, 1'b0, 1'b1, 32'h00002248, 32'h0);
    chk(d_rdata, ln[95:64], "dirty dropped");
    chk(n_push - p, 1, "push count");
    cpu(2'h0, 1'b1, 1'b0, 32'h00002244, 32'h12345678);
    chk({wt_a, wt_d}, {32'h00002244, 32'h12345678}, "wt hit");
    cpu(2'h0, 1'b0, 1'b0, 32'h00002244, 32'h0);
    chk(d_rdata, 32'h12345678, "wt word");
    f = n_fill;
    cpu(2'h0, 1'b1, 1'b0, 32'h00003244, 32'h0000beef);
    chk({wt_a, n_fill - f}, {32'h00003244, 32'h0}, "wt miss");
    $display("t_dcache done");
  end
  endtask
  task t_victim;
  begin
    for (p = 0; p < 4; p = p + 1)
      cpu(2'h0, 1'b1, 1'b1, 32'h00003350 + p * 32'h100, p);
    delay <= 5'h14;
    p = n_push;
    cpu(2'h0, 1'b0, 1'b1, 32'h00003750, 32'h0);
    ln = bus.line_of(32'h00003750);
    chk(d_rdata, ln[31:0], "fill before push");
    @(negedge core_clk);
    chk({push_req, n_push - p}, {1'b1, 32'h0}, "push waits");
    @(posedge core_clk);
    for (f = 0; f < 4; f = f + 1)
      snoop(1'b0, 2'h1, 32'h00003350 + f * 32'h100, 1'b1);
    delay <= 5'h00;
    cpu(2'h0, 1'b0, 1'b1, 32'h00003750, 32'h0);
    chk({n_push - p, flags}, {32'h1, 4'h1}, "victim push");
    $display("t_victim done");
  end
  endtask
  task tally_and_finish;
  begin
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    {core_clk, nrst, flow_change, processor_status_word_wr} = 4'h0;
    {i_req, d_req, d_wr, page_caching_policy, op_req, op_push} = 6'h0;
    {op_dcache, snp_valid, snp_wr, snp_ctl, delay} = 10'h0;
    {i_addr, d_addr, d_wdata, op_addr, snp_addr} = 160'h0;
    {n_mismatch, n_compared, n_fill, n_push, cycles} = 160'h0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    {flow_change, processor_status_word_wr} <= 2'h3;
    @(posedge core_clk);
    {flow_change, processor_status_word_wr} <= 2'h0;
    t_icache;
    t_dcache;
    t_victim;
    tally_and_finish;
  end
endmodule
bind cache_line_ctrl cache_line_ctrl_chk chk (.core_clk, .nrst,
  .flow_change, .processor_status_word_wr, .i_req, .i_busy, .i_ack,
  .d_req, .d_busy, .d_ack, .op_req, .op_busy, .op_ack, .line_rd_req,
  .line_rd_addr, .line_rd_done, .wt_req, .wt_addr, .wt_data, .wt_done,
  .push_req, .snp_valid, .snp_wr, .snp_inhibit);
